// *** hdl/ihss_pkg.sv ***
// package for the idle head sweep scheduler: timing constants, states, widths
// assumes a 50 MHz system clock
package ihss_pkg;
    localparam int unsigned CLK_HZ = 50000000;
    localparam int unsigned SWEEP_INTERVAL_MIN = 12;
    localparam int unsigned IDLE_TIMEOUT_MIN = 15;
    localparam longint unsigned SWEEP_INTERVAL_CYC = 64'(SWEEP_INTERVAL_MIN) * 60 * CLK_HZ;
    localparam longint unsigned IDLE_TIMEOUT_CYC = 64'(IDLE_TIMEOUT_MIN) * 60 * CLK_HZ;
    localparam int unsigned CNT_W = 36;
    localparam int unsigned CYL_W = 16;
    localparam logic [CYL_W-1:0] ONE_TRACK = 16'h0001;
    localparam logic STRAP_DEFAULT = 1'b1;
    typedef enum logic [1:0] {
        IHSS_IDLE = 2'b00,
        IHSS_SWEEP = 2'b01,
        IHSS_SEEK = 2'b10
    } ihss_state_e;
endpackage

// *** hdl/ihss_timer.sv ***
// one-shot down-counter: load restarts it, expired is a level once it reaches zero
// assumes a single clock and an active-low asynchronous reset
module ihss_timer
    import ihss_pkg::*;
(
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic load,
    input wire logic [CNT_W-1:0] load_val,
    output logic expired
);
    logic [CNT_W-1:0] cnt_r;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            cnt_r <= '0;
        end else if (load) begin
            cnt_r <= load_val;
        end else if (cnt_r != '0) begin
            cnt_r <= cnt_r - 1'b1;
        end
    end

    assign expired = (cnt_r == '0);
endmodule

// *** hdl/ihss_scheduler.sv ***
// idle head sweep scheduler: decides when a sweep precedes a seek
// assumes positioning logic acks sweeps and seeks with done pulses
// Contract
// [R1] a strap sampled after reset enables sweeping when fitted and disables it when open.
// [R2] the strap defaults to fitted, so sweeping is enabled unless the strap is removed.
// [R3] a sweep starts only together with a seek, requested or implied by read or write.
// [R4] every performed sweep restarts a twelve-minute sweep-interval timer.
// [R5] after the interval expires the sweep stays pending until the next seek.
// [R6] a pending sweep combined with a seek runs the sweep fully before the seek.
// [R7] after a seek-triggered sweep the heads go to the cylinder the seek asked for.
// [R8] fifteen idle minutes with no disc access inject a one-track seek that sweeps.
// [R9] the idle timer restarts on each disc access command and on each injected seek.
module ihss_scheduler
    import ihss_pkg::*;
#(
    parameter longint unsigned SWEEP_CYC = SWEEP_INTERVAL_CYC,
    parameter longint unsigned IDLE_CYC = IDLE_TIMEOUT_CYC
)
(
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic sweep_strap,
    input wire logic seek_req,
    input wire logic [CYL_W-1:0] seek_cyl,
    input wire logic disc_access,
    input wire logic sweep_done,
    input wire logic seek_done,
    output logic seek_ready,
    output logic sweep_start,
    output logic seek_start,
    output logic [CYL_W-1:0] seek_target,
    output logic sweep_pending,
    output logic sweep_enabled,
    output logic busy
);
    ihss_state_e state_r;
    logic strap_seen_r;
    logic enable_r;
    logic pending_r;
    logic [CYL_W-1:0] cyl_r;
    logic sweep_start_r;
    logic seek_start_r;
    logic inject;
    logic take;
    logic sweep_expired;
    logic idle_expired;
    logic sweep_reload;
    logic idle_reload;

    // strap caught once after release of reset
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            strap_seen_r <= 1'b0;
            enable_r <= STRAP_DEFAULT; // [R2]
        end else if (!strap_seen_r) begin
            strap_seen_r <= 1'b1;
            enable_r <= sweep_strap; // [R1]
        end
    end

    assign inject = (state_r == IHSS_IDLE) && !seek_req && idle_expired && strap_seen_r;
    assign seek_ready = (state_r == IHSS_IDLE) && strap_seen_r;
    assign take = (seek_ready && seek_req) || inject;

    // interval timer restarts whenever a sweep is done
    assign sweep_reload = !strap_seen_r || ((state_r == IHSS_SWEEP) && sweep_done); // [R4]
    assign idle_reload = !strap_seen_r || disc_access || inject; // [R9]

    ihss_timer u_sweep_tmr (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .load(sweep_reload),
        .load_val(CNT_W'(SWEEP_CYC)),
        .expired(sweep_expired)
    );

    ihss_timer u_idle_tmr (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .load(idle_reload),
        .load_val(CNT_W'(IDLE_CYC)),
        .expired(idle_expired)
    );

    // pending flag: set on expiry, cleared when the sweep starts
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            pending_r <= 1'b0;
        end else if (!enable_r || !strap_seen_r) begin
            pending_r <= 1'b0; // [R1]
        end else if (take && pending_r) begin
            pending_r <= 1'b0;
        end else if (sweep_expired && state_r == IHSS_IDLE) begin
            pending_r <= 1'b1; // [R5]
        end
    end

    // sequencer
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_r <= IHSS_IDLE;
        end else begin
            unique case (state_r)
                IHSS_IDLE: begin
                    if (take) begin
                        state_r <= pending_r ? IHSS_SWEEP : IHSS_SEEK; // [R3] [R6]
                    end
                end
                IHSS_SWEEP: begin
                    if (sweep_done) begin
                        state_r <= IHSS_SEEK; // [R6]
                    end
                end
                IHSS_SEEK: begin
                    if (seek_done) begin
                        state_r <= IHSS_IDLE;
                    end
                end
                default: begin
                    state_r <= IHSS_IDLE;
                end
            endcase
        end
    end

    // requested cylinder held for the seek after the sweep
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            cyl_r <= '0;
        end else if (take) begin
            cyl_r <= inject ? ONE_TRACK : seek_cyl; // [R7] [R8]
        end
    end

    // start pulses
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            sweep_start_r <= 1'b0;
            seek_start_r <= 1'b0;
        end else begin
            sweep_start_r <= take && pending_r; // [R3]
            seek_start_r <= (take && !pending_r) || (state_r == IHSS_SWEEP && sweep_done); // [R7]
        end
    end

    assign sweep_start = sweep_start_r;
    assign seek_start = seek_start_r;
    assign seek_target = cyl_r;
    assign sweep_pending = pending_r;
    assign sweep_enabled = enable_r;
    assign busy = (state_r != IHSS_IDLE);

    AST_SWEEP_NEEDS_SEEK: assert property (@(posedge sys_clk) disable iff (!reset_n)
        sweep_start |-> $past(take)) // [R3]
        else $error("sweep started without a seek");
    AST_SWEEP_ONLY_ENABLED: assert property (@(posedge sys_clk) disable iff (!reset_n)
        sweep_start |-> enable_r) // [R1]
        else $error("sweep while strap open");
    AST_SWEEP_BEFORE_SEEK: assert property (@(posedge sys_clk) disable iff (!reset_n)
        sweep_start |-> !seek_start ##1 (state_r == IHSS_SWEEP)) // [R6]
        else $error("seek overlapped sweep");
    AST_SEEK_AFTER_SWEEP: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (state_r == IHSS_SWEEP && sweep_done) |=> seek_start && state_r == IHSS_SEEK) // [R7]
        else $error("no seek after sweep");
    AST_TARGET_KEPT: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (seek_ready && seek_req) |=> cyl_r == $past(seek_cyl)) // [R7]
        else $error("requested cylinder lost");
    AST_INTERVAL_RESTART: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (state_r == IHSS_SWEEP && sweep_done) |=> !sweep_expired) // [R4]
        else $error("interval not restarted");
    AST_PENDING_HOLDS: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (pending_r && !take && enable_r) |=> pending_r) // [R5]
        else $error("pending sweep dropped");
    AST_INJECT_ONE_TRACK: assert property (@(posedge sys_clk) disable iff (!reset_n)
        inject |=> cyl_r == ONE_TRACK && !idle_expired) // [R8] [R9]
        else $error("idle seek wrong");
    AST_ACCESS_RESTARTS: assert property (@(posedge sys_clk) disable iff (!reset_n)
        disc_access |=> !idle_expired) // [R9]
        else $error("idle timer not restarted");
    AST_PLAIN_SEEK_ANSWER: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (seek_ready && seek_req && !pending_r) |=> seek_start && !sweep_start && busy) // [R3]
        else $error("plain seek not started");
    AST_PENDING_SWEEPS: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (seek_ready && seek_req && pending_r) |=> sweep_start && !seek_start) // [R5] [R6]
        else $error("pending sweep not run");
    AST_INJECT_SWEEPS: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (inject && pending_r) |=> sweep_start) // [R8]
        else $error("idle seek did not sweep");
    AST_INJECT_BUSY: assert property (@(posedge sys_clk) disable iff (!reset_n)
        inject |=> busy) // [R8]
        else $error("idle seek not started");
    AST_OPEN_NO_PENDING: assert property (@(posedge sys_clk) disable iff (!reset_n)
        !enable_r |-> !pending_r) // [R1]
        else $error("sweep pending while strap open");
    AST_STRAP_ONCE: assert property (@(posedge sys_clk) disable iff (!reset_n)
        strap_seen_r |=> strap_seen_r && $stable(enable_r)) // [R1]
        else $error("strap sampled twice");
    AST_TARGET_HELD: assert property (@(posedge sys_clk) disable iff (!reset_n)
        busy |=> $stable(cyl_r)) // [R7]
        else $error("target changed while busy");
    AST_SWEEP_CLEARS: assert property (@(posedge sys_clk) disable iff (!reset_n)
        sweep_start |-> !pending_r) // [R5]
        else $error("pending kept after sweep start");
    AST_SEEK_PULSE: assert property (@(posedge sys_clk) disable iff (!reset_n)
        seek_start |=> !seek_start) // [R7]
        else $error("seek start too long");
    AST_SWEEP_PULSE: assert property (@(posedge sys_clk) disable iff (!reset_n)
        sweep_start |=> !sweep_start) // [R6]
        else $error("sweep start too long");
    AST_SEEK_DONE_IDLE: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (state_r == IHSS_SEEK && seek_done) |=> !busy) // [R7]
        else $error("busy after seek done");

    COV_SWEEP_SEEK: cover property (@(posedge sys_clk) disable iff (!reset_n)
        sweep_start ##[1:50] seek_start);
    COV_PLAIN_SEEK: cover property (@(posedge sys_clk) disable iff (!reset_n)
        seek_start && !$past(busy));
    COV_INJECT: cover property (@(posedge sys_clk) disable iff (!reset_n) inject);
    COV_OPEN_STRAP_SEEK: cover property (@(posedge sys_clk) disable iff (!reset_n)
        !enable_r && seek_start);
    COV_PENDING_WAITS: cover property (@(posedge sys_clk) disable iff (!reset_n)
        pending_r && !busy ##1 take);
endmodule

// *** tb/ihss_pos_model.sv ***
// positioning logic model: answers each start pulse with a done pulse
// assumes start pulses one cycle wide, dly sets the answer delay in cycles
module ihss_pos_model (
    input wire logic sys_clk,
    input wire logic sweep_start,
    input wire logic seek_start,
    input wire logic [3:0] dly,
    output logic sweep_done,
    output logic seek_done
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        sweep_done = 1'b0;
        seek_done = 1'b0;
    end
    always @(posedge sys_clk) begin
        if (sweep_start === 1'b1) begin
            repeat (int'(dly) + 1) @(posedge sys_clk);
            sweep_done <= 1'b1;
            @(posedge sys_clk);
            sweep_done <= 1'b0;
        end
    end
    always @(posedge sys_clk) begin
        if (seek_start === 1'b1) begin
            repeat (int'(dly) + 1) @(posedge sys_clk);
            seek_done <= 1'b1;
            @(posedge sys_clk);
            seek_done <= 1'b0;
        end
    end
endmodule

// *** tb/tb_idle_head_sweep_scheduler.sv ***
// bench for the sweep scheduler with shortened timers
// assumes the positioning model answers every start pulse
module tb_idle_head_sweep_scheduler import ihss_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int SW = 200;
    localparam int ID = 300;
    logic sys_clk = 0, reset_n = 0, sweep_strap = 1, seek_req = 0, disc_access = 0, en = 1;
    logic [CYL_W-1:0] seek_cyl = 16'h0000, seek_target;
    logic sweep_done, seek_done, seek_ready, sweep_start, seek_start;
    logic sweep_pending, sweep_enabled, busy;
    logic [3:0] dly = 4'h3;
    logic [31:0] lfsr = 32'h4C99467A;
    int n_mismatch = 0, samples_checked = 0, cyc = 0, last_sw = 0, n_sw = 0, n_sk = 0;
    function automatic logic [31:0] nxt(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    initial forever #10 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (sweep_start === 1'b1) n_sw <= n_sw + 1;
        if (seek_start === 1'b1) n_sk <= n_sk + 1;
    end
    ihss_scheduler #(.SWEEP_CYC(SW), .IDLE_CYC(ID)) dut (.sys_clk(sys_clk), .reset_n(reset_n),
        .sweep_strap(sweep_strap), .seek_req(seek_req), .seek_cyl(seek_cyl),
        .disc_access(disc_access), .sweep_done(sweep_done), .seek_done(seek_done),
        .seek_ready(seek_ready), .sweep_start(sweep_start), .seek_start(seek_start),
        .seek_target(seek_target), .sweep_pending(sweep_pending),
        .sweep_enabled(sweep_enabled), .busy(busy));
    ihss_pos_model pos (.sys_clk(sys_clk), .sweep_start(sweep_start), .seek_start(seek_start),
        .dly(dly), .sweep_done(sweep_done), .seek_done(seek_done));
    task stop_test;
        $display("counts: %0d mismatches, %0d checked", n_mismatch, samples_checked);
        if (n_mismatch == 0 && samples_checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task chk(input logic [CYL_W-1:0] got, input logic [CYL_W-1:0] exp, input string m);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("FAIL %0t %s", $time, m);
        end
    endtask
    task fail;
        n_mismatch++;
        $display("FAIL %0t wait ran out", $time);
        stop_test;
    endtask
    task rst(input logic s);
        sweep_strap <= s;
        reset_n <= 1'b0;
        repeat (5) @(posedge sys_clk);
        reset_n <= 1'b1;
        repeat (2) @(posedge sys_clk);
        last_sw = cyc;
    endtask
    task automatic wait_start(input logic [CYL_W-1:0] tgt, input logic sw);
        int k;
        int s0;
        s0 = n_sw;
        for (k = 0; k < 500 && seek_start !== 1'b1; k++) @(negedge sys_clk);
        if (k == 500) fail;
        chk(seek_target, tgt, "seek target");
        chk(16'(n_sw - s0), 16'(sw), "sweep count");
        if (sw) last_sw = cyc;
        for (k = 0; k < 50 && busy !== 1'b0; k++) @(negedge sys_clk);
        if (k == 50) fail;
        $display("seek done at %0t", $time);
    endtask
    task automatic do_seek;
        logic [CYL_W-1:0] c;
        int k;
        lfsr = nxt(lfsr);
        c = lfsr[15:0];
        @(posedge sys_clk);
        disc_access <= 1'b1;
        dly <= lfsr[19:16];
        @(posedge sys_clk);
        disc_access <= 1'b0;
        seek_req <= 1'b1;
        seek_cyl <= c;
        for (k = 0; k < 20; k++) begin
            @(negedge sys_clk);
            if (seek_ready === 1'b1) break;
        end
        if (k == 20) fail;
        @(posedge sys_clk);
        seek_req <= 1'b0;
        wait_start(c, en && (cyc - last_sw > SW));
    endtask
    initial begin
        rst(1'b1);
        chk(16'(sweep_enabled), 16'h0001, "strap fitted");
        do_seek();
        repeat (240) @(posedge sys_clk);
        chk(16'(sweep_pending), 16'(en && (cyc - last_sw > SW)), "pending flag");
        do_seek();
        do_seek();
        wait_start(ONE_TRACK, 1'b1);
        begin : keep_awake
            int s1;
            s1 = n_sk;
            repeat (4) begin
                repeat (200) @(posedge sys_clk);
                disc_access <= 1'b1;
                @(posedge sys_clk);
                disc_access <= 1'b0;
            end
            chk(16'(n_sk - s1), 16'h0000, "idle seek despite access");
        end
        rst(1'b0);
        en = 1'b0;
        chk(16'(sweep_enabled), 16'h0000, "strap open");
        repeat (240) @(posedge sys_clk);
        chk(16'(sweep_pending), 16'(en && (cyc - last_sw > SW)), "pending open");
        do_seek();
        stop_test;
    end
endmodule
